// file: hdl/charge_time_unit.sv
`timescale 1ns/1ps
module charge_time_unit (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        IDLE_MODE,
  input  wire logic        HW_EDGE1,
  input  wire logic        HW_EDGE2,
  output logic             SOURCE_GROUND,
  output logic             CONVERT_TRIGGER,
  output logic             DELAY_ACTIVE,
  output logic             UNIT_RUNNING
);
  import ctu_pkg::*;
  ctu_ctrl_if cif ();
  logic [15:0] control_reg;
  logic        sw1_reg;
  logic        sw2_reg;
  logic        clr_reg;
  logic        run;
  logic        setup;
  logic        access;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        delay_w;
  logic        trig_w;
  // ****************************************
  // apb decode
  // ****************************************
  // slave answers in the first access cycle, so pready is held high;
  // read data is fetched at setup, writes land only when the transfer completes
  assign setup   = PSEL && !PENABLE;
  assign access  = PSEL && PENABLE && PREADY;
  assign wr_ctrl = access && PWRITE && (PADDR == CONTROL_OFF);
  assign wr_stat = access && PWRITE && (PADDR == EDGE_STAT_OFF);
  assign run     = control_reg[ENABLE_BIT] && !(control_reg[IDLE_STOP_BIT] && IDLE_MODE);
  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      control_reg <= CONTROL_RESET;
    end else if (CE && wr_ctrl) begin
      control_reg <= PWDATA[15:0] & CONTROL_MASK;
    end
  end
  // software edge writes; set requests only honoured with software edges selected, an all-zero write clears in either mode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sw1_reg <= 1'b0;
      sw2_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else if (CE) begin
      sw1_reg <= wr_stat && PWDATA[EDGE1_BIT];
      sw2_reg <= wr_stat && PWDATA[EDGE2_BIT];
      clr_reg <= wr_stat && !PWDATA[EDGE1_BIT] && !PWDATA[EDGE2_BIT];
    end
  end
  assign cif.run         = run;
  assign cif.hw_edge     = control_reg[HW_EDGE_BIT];
  assign cif.seq         = control_reg[SEQ_BIT];
  assign cif.time_generation_enable        = control_reg[TIME_GENERATION_ENABLE_BIT];
  assign cif.sw_edge1    = sw1_reg;
  assign cif.sw_edge2    = sw2_reg;
  assign cif.clear_edges = clr_reg;
  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= 1'b1;
      PSLVERR <= setup && (PADDR != CONTROL_OFF) && (PADDR != EDGE_STAT_OFF);
      if (setup && !PWRITE) begin
        if (PADDR == CONTROL_OFF) begin
          PRDATA <= {16'h0000, control_reg & CONTROL_MASK};
        end else if (PADDR == EDGE_STAT_OFF) begin
          PRDATA <= {30'h0, cif.edge_stat};
        end else begin
          PRDATA <= 32'h00000000;
        end
      end
    end
  end
  // ****************************************
  // analog and converter controls
  // ****************************************
  // grounding is independent of run so software can discharge before enabling;
  // the converter must be sampling meanwhile, which this block does not check
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SOURCE_GROUND   <= 1'b0;
      CONVERT_TRIGGER <= 1'b0;
      DELAY_ACTIVE    <= 1'b0;
      UNIT_RUNNING    <= 1'b0;
    end else if (CE) begin
      SOURCE_GROUND   <= control_reg[GROUND_BIT];
      CONVERT_TRIGGER <= trig_w;
      DELAY_ACTIVE    <= delay_w;
      UNIT_RUNNING    <= run;
    end
  end
  ctu_edge_logic u_edge (
    .clk          (CLK),
    .rst_n        (RST_N),
    .ce           (CE),
    .hw_edge1     (HW_EDGE1),
    .hw_edge2     (HW_EDGE2),
    .bus          (cif),
    .delay_active (delay_w)
  );
  ctu_trigger u_trig (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .arm   (run && control_reg[TRIG_BIT]),
    .edge2 (cif.edge_stat[EDGE2_BIT]),
    .pulse (trig_w)
  );
endmodule : charge_time_unit

// file: include/ctu_pkg.sv
package ctu_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CONTROL_OFF    = 12'h000;
  localparam logic [11:0] EDGE_STAT_OFF  = 12'h004;
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_MASK   = 16'hbf00;
  localparam int          ENABLE_BIT     = 15;
  localparam int          IDLE_STOP_BIT  = 13;
  localparam int          TIME_GENERATION_ENABLE_BIT       = 12;
  localparam int          HW_EDGE_BIT    = 11;
  localparam int          SEQ_BIT        = 10;
  localparam int          GROUND_BIT     = 9;
  localparam int          TRIG_BIT       = 8;
  localparam int          EDGE1_BIT      = 0;
  localparam int          EDGE2_BIT      = 1;
  localparam logic [1:0]  EDGE_RESET     = 2'h0;
endpackage : ctu_pkg

// file: include/ctu_ctrl_if.sv
`timescale 1ns/1ps
interface ctu_ctrl_if;
  logic       run;
  logic       hw_edge;
  logic       seq;
  logic       time_generation_enable;
  logic       sw_edge1;
  logic       sw_edge2;
  logic       clear_edges;
  logic [1:0] edge_stat;
  modport ctrl (output run, hw_edge, seq, time_generation_enable, sw_edge1, sw_edge2, clear_edges, input edge_stat);
  modport edge_side (input run, hw_edge, seq, time_generation_enable, sw_edge1, sw_edge2, clear_edges, output edge_stat);
endinterface : ctu_ctrl_if

// file: hdl/ctu_edge_logic.sv
`timescale 1ns/1ps
module ctu_edge_logic (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   ce,
  input  wire logic   hw_edge1,
  input  wire logic   hw_edge2,
  ctu_ctrl_if.edge_side bus,
  output logic        delay_active
);
  import ctu_pkg::*;
  logic [1:0] stat_reg;
  logic       e1;
  logic       e2;
  assign bus.edge_stat = stat_reg;
  // ****************************************
  // edge source and ordering
  // ****************************************
  always_comb begin
    e1 = bus.hw_edge ? hw_edge1 : bus.sw_edge1;
    e2 = bus.hw_edge ? hw_edge2 : bus.sw_edge2;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= EDGE_RESET;
    end else if (ce) begin
      if (bus.clear_edges) begin
        stat_reg <= EDGE_RESET;
      end
      // set beats clear in the same cycle
      if (bus.run && e1) begin
        stat_reg[EDGE1_BIT] <= 1'b1;
      end
      if (bus.run && e2 && (!bus.seq || stat_reg[EDGE1_BIT] || e1)) begin
        stat_reg[EDGE2_BIT] <= 1'b1;
      end
    end
  end
  // delay window: open between edge 1 and edge 2 while generation on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_active <= 1'b0;
    end else if (ce) begin
      delay_active <= bus.run && bus.time_generation_enable && stat_reg[EDGE1_BIT] && !stat_reg[EDGE2_BIT];
    end
  end
endmodule : ctu_edge_logic

// file: hdl/ctu_trigger.sv
`timescale 1ns/1ps
module ctu_trigger (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic arm,
  input  wire logic edge2,
  output logic      pulse
);
  logic edge2_d_reg;
  // one pulse on the rising of the edge-2 status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge2_d_reg <= 1'b0;
      pulse       <= 1'b0;
    end else if (ce) begin
      edge2_d_reg <= edge2;
      pulse       <= arm && edge2 && !edge2_d_reg;
    end
  end
endmodule : ctu_trigger

// file: bench/ctu_properties.sv
`timescale 1ns/1ps
module ctu_checker (
  input wire logic        CLK, RST_N, CE, PSEL, PENABLE, PWRITE, IDLE_MODE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  input wire logic        PREADY, PSLVERR, SOURCE_GROUND, CONVERT_TRIGGER, DELAY_ACTIVE, UNIT_RUNNING
);
  import ctu_pkg::*;
  logic [15:0] shadow_reg;
  logic        acc;
  assign acc = PSEL && PENABLE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // unmasked mirror of the control word writes, taken at the completing access edge like the block itself
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) shadow_reg <= CONTROL_RESET;
    else if (CE && acc && PREADY && PWRITE && PADDR == CONTROL_OFF) shadow_reg <= PWDATA[15:0];
  property p_run; UNIT_RUNNING == $past(shadow_reg[15] && !(shadow_reg[13] && IDLE_MODE)); endproperty
  a_run: assert property (p_run) else $error("running flag wrong");
  property p_ground; SOURCE_GROUND == $past(shadow_reg[9]); endproperty
  a_ground: assert property (p_ground) else $error("ground output wrong");
  property p_ctl_read; acc && !PWRITE && PADDR == CONTROL_OFF |-> PRDATA == {16'h0000, shadow_reg & CONTROL_MASK};
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  property p_stat_read; acc && !PWRITE && PADDR == EDGE_STAT_OFF |-> PRDATA[31:2] == 30'h0; endproperty
  a_stat_read: assert property (p_stat_read) else $error("status upper bits set");
  property p_err; acc |-> PSLVERR == !(PADDR == CONTROL_OFF || PADDR == EDGE_STAT_OFF); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_ready; acc |-> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_delay; !$past(shadow_reg[12]) && !$past(shadow_reg[12], 2) |-> !DELAY_ACTIVE; endproperty
  a_delay: assert property (p_delay) else $error("delay without time generation");
  property p_trig; CONVERT_TRIGGER |-> ($past(shadow_reg[8]) || $past(shadow_reg[8], 2)) ##1 !CONVERT_TRIGGER;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse wrong");
endmodule : ctu_checker
bind charge_time_unit ctu_checker i_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .IDLE_MODE(IDLE_MODE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SOURCE_GROUND(SOURCE_GROUND), .CONVERT_TRIGGER(CONVERT_TRIGGER),
  .DELAY_ACTIVE(DELAY_ACTIVE), .UNIT_RUNNING(UNIT_RUNNING));

// file: bench/ctu_far_side.sv
`timescale 1ns/1ps
module ctu_far_side (
  input  wire logic clk,
  input  wire logic trigger,
  input  wire logic ground,
  output logic      edge1,
  output logic      edge2
);
  int   trig_count = 0;
  logic sampling;
  initial begin
    edge1 = 1'b0;
    edge2 = 1'b0;
  end
  // the converter keeps sampling while grounded, else the discharge never reaches the array
  assign sampling = ground;
  always @(posedge clk) if (trigger === 1'b1) trig_count++;
  task automatic pulse(input logic a, input logic b);
    edge1 <= a;
    edge2 <= b;
    @(posedge clk);
    edge1 <= 1'b0;
    edge2 <= 1'b0;
    @(posedge clk);
  endtask : pulse
endmodule : ctu_far_side

// file: bench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: %h not %h", $time, a, b); end end
module tb;
  import ctu_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, ground, trig, delay, run, e1, e2;
  int          mismatches = 0, checked = 0;
  charge_time_unit i_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IDLE_MODE(idle),
    .HW_EDGE1(e1), .HW_EDGE2(e2), .SOURCE_GROUND(ground), .CONVERT_TRIGGER(trig), .DELAY_ACTIVE(delay),
    .UNIT_RUNNING(run));
  ctu_far_side i_far (.clk(clk), .trigger(trig), .ground(ground), .edge1(e1), .edge2(e2));
  initial forever #12.5 clk = ~clk;
  task automatic stop_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin mismatches++; $display("mismatch at %0t: no ready", $time); stop_test(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r; logic e;
    xfer(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask : rd
  task automatic settle(); repeat (3) @(posedge clk); endtask : settle
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CONTROL_OFF, 32'h0, 1'b0);
    wr(CONTROL_OFF, 32'hffffffff);
    rd(CONTROL_OFF, 32'h0000bf00, 1'b0);
    settle();
    `CHK(ground, 1'b1)
    `CHK(i_far.sampling, 1'b1)
    `CHK(run, 1'b1)
    idle <= 1'b1;
    settle();
    `CHK(run, 1'b0)
    wr(CONTROL_OFF, 32'h8000);
    settle();
    `CHK(run, 1'b1)
    idle <= 1'b0;
    rd(12'h008, 32'h0, 1'b1);
    wr(CONTROL_OFF, 32'h8300);
    wr(CONTROL_OFF, 32'h8100);
    wr(EDGE_STAT_OFF, 32'h0);
    wr(EDGE_STAT_OFF, 32'h2);
    rd(EDGE_STAT_OFF, 32'h2, 1'b0);
    settle();
    `CHK(i_far.trig_count, 1)
    wr(CONTROL_OFF, 32'h8500);
    wr(EDGE_STAT_OFF, 32'h0);
    wr(EDGE_STAT_OFF, 32'h2);
    rd(EDGE_STAT_OFF, 32'h0, 1'b0);
    wr(EDGE_STAT_OFF, 32'h1);
    wr(EDGE_STAT_OFF, 32'h2);
    rd(EDGE_STAT_OFF, 32'h3, 1'b0);
    wr(EDGE_STAT_OFF, 32'h0);
    wr(CONTROL_OFF, 32'h8800);
    i_far.pulse(1'b1, 1'b0);
    i_far.pulse(1'b0, 1'b1);
    rd(EDGE_STAT_OFF, 32'h3, 1'b0);
    wr(CONTROL_OFF, 32'h9000);
    wr(EDGE_STAT_OFF, 32'h0);
    wr(EDGE_STAT_OFF, 32'h1);
    settle();
    `CHK(delay, 1'b1)
    wr(CONTROL_OFF, 32'h8000);
    settle();
    `CHK(delay, 1'b0)
    `CHK(i_far.trig_count, 2)
    ce <= 1'b0;
    wr(CONTROL_OFF, 32'h00000000);
    ce <= 1'b1;
    rd(CONTROL_OFF, 32'h00008000, 1'b0);
    `CHK(run, 1'b1)
    stop_test();
  end
endmodule : tb
